// ### hw/mpd_cfg.svh
// Offsets, field positions, reset values and masks for the motor pin and device setup registers
`ifndef MPD_CFG_SVH
`define MPD_CFG_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define MPD_SYS_OFS      8'ha6
`define MPD_PIN_OFS      8'ha4
`define MPD_SYS_RST      32'h0000_0000
`define MPD_PIN_RST      32'h0000_0000
// Reserved bit and key field never read back
`define MPD_SYS_RD_MASK  32'hbff0_001f

// ----------------------------------------------------------------
// Pin function setup fields
// ----------------------------------------------------------------
`define MPD_TACH_HI      8
`define MPD_TACH_LO      7
`define MPD_BRK_ACT_BIT  5
`define MPD_HOLD_BIT     4
`define MPD_BRK_SRC_HI   3
`define MPD_BRK_SRC_LO   2
`define MPD_SPD_HI       1
`define MPD_SPD_LO       0

// ----------------------------------------------------------------
// System setup word fields
// ----------------------------------------------------------------
`define MPD_RSV_BIT      30
`define MPD_MON_HI       29
`define MPD_MON_LO       28
`define MPD_DITH_BIT     27
`define MPD_TADDR_HI     26
`define MPD_TADDR_LO     20
`define MPD_KEY_HI       19
`define MPD_KEY_LO       5
`define MPD_PULL_BIT     2
`define MPD_SUP_HI       1
`define MPD_SUP_LO       0

`endif

// ### hw/mpd_pkg.sv
// Types shared by the motor pin and device setup register block
package mpd_pkg;

  typedef enum logic [1:0] {
    TACH_HOLD_LAST = 2'b00,
    TACH_FORCE_HI  = 2'b01,
    TACH_FORCE_LO  = 2'b10,
    TACH_TILL_BEMF = 2'b11
  } mpd_tach_mode_t;

  typedef enum logic [1:0] {
    BRK_SRC_PIN   = 2'b00,
    BRK_SRC_FORCE = 2'b01,
    BRK_SRC_NONE  = 2'b10,
    BRK_SRC_PIN3  = 2'b11
  } mpd_brake_src_t;

  typedef enum logic [1:0] {
    SPD_ANALOG = 2'b00,
    SPD_DUTY   = 2'b01,
    SPD_BUS    = 2'b10,
    SPD_FREQ   = 2'b11
  } mpd_speed_src_t;

  typedef enum logic [1:0] {
    MON_CONV_TWO = 2'b00,
    MON_PHASE_A  = 2'b01,
    MON_PHASE_B  = 2'b10,
    MON_PHASE_C  = 2'b11
  } mpd_mon_sel_t;

  typedef enum logic [1:0] {
    SUP_15V = 2'b00,
    SUP_30V = 2'b01,
    SUP_40V = 2'b10,
    SUP_NA  = 2'b11
  } mpd_supply_t;

endpackage

// ### hw/mpd_cfg_if.sv
// Setup fields from the register bank, plus back-EMF level and threshold inputs, carried to the tach and brake helpers
interface mpd_cfg_if #(parameter int BEMF_W = 12);
  mpd_pkg::mpd_tach_mode_t tach_mode;
  logic [BEMF_W-1:0]       backemf;
  logic [BEMF_W-1:0]       bemf_thr;
  mpd_pkg::mpd_brake_src_t brake_src;
  logic                    brake_align_sel;

  modport drv (output tach_mode, backemf, bemf_thr, brake_src, brake_align_sel);
  modport sink (input tach_mode, backemf, bemf_thr, brake_src, brake_align_sel);
endinterface

// ### hw/mpd_tach_ctl.sv
// Tach output behaviour in and out of fault
module mpd_tach_ctl (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  mpd_cfg_if.sink   cfg,
  input  wire logic fault_i,
  input  wire logic tach_raw_i,
  output logic      tach_o
);
  import mpd_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_FOLLOW = 2'b01,
    ST_FROZEN = 2'b10
  } mpd_tach_st_t;

  mpd_tach_st_t st_reg;
  mpd_tach_st_t st_next;
  logic         tach_next;
  wire          bemf_low = cfg.backemf < cfg.bemf_thr;

  always_comb begin
    st_next   = st_reg;
    tach_next = tach_o;
    case (st_reg)
      ST_RUN: begin
        tach_next = tach_raw_i;
        if (fault_i) st_next = ST_FOLLOW;
      end
      ST_FOLLOW, ST_FROZEN: begin
        case (cfg.tach_mode)
          TACH_HOLD_LAST: tach_next = tach_o;
          TACH_FORCE_HI:  tach_next = 1'b1;
          TACH_FORCE_LO:  tach_next = 1'b0;
          default: tach_next = (st_reg == ST_FOLLOW && !bemf_low) ? tach_raw_i : tach_o;
        endcase
        if (!fault_i) st_next = ST_RUN;
        else if (st_reg == ST_FOLLOW && bemf_low) st_next = ST_FROZEN;
      end
      default: st_next = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= ST_RUN;
      tach_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      tach_o <= tach_next;
    end
  end

  property p_tach_force_hi;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_reg != ST_RUN && fault_i && cfg.tach_mode == TACH_FORCE_HI) |=> tach_o;
  endproperty
  a_tach_force_hi: assert property (p_tach_force_hi) else $error("tach not forced high");

  property p_tach_force_lo;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_reg != ST_RUN && cfg.tach_mode == TACH_FORCE_LO) |=> !tach_o;
  endproperty
  a_tach_force_lo: assert property (p_tach_force_lo) else $error("tach not forced low");

  property p_tach_hold;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_reg != ST_RUN && cfg.tach_mode == TACH_HOLD_LAST) |=> $stable(tach_o);
  endproperty
  a_tach_hold: assert property (p_tach_hold) else $error("tach did not hold");

  property p_tach_follow;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_reg == ST_FOLLOW && cfg.tach_mode == TACH_TILL_BEMF && !bemf_low)
        |=> tach_o == $past(tach_raw_i);
  endproperty
  a_tach_follow: assert property (p_tach_follow) else $error("tach stopped early");
endmodule

// ### hw/mpd_brake_ctl.sv
// Brake request selection between pin and override
module mpd_brake_ctl (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  mpd_cfg_if.sink   cfg,
  input  wire logic brake_pin_sync_i,
  output logic      brake_lowside_o,
  output logic      brake_align_o
);
  import mpd_pkg::*;

  logic brake_req;

  always_comb begin
    case (cfg.brake_src)
      BRK_SRC_FORCE: brake_req = 1'b1;
      BRK_SRC_NONE:  brake_req = 1'b0;
      default:       brake_req = brake_pin_sync_i;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brake_lowside_o <= 1'b0;
      brake_align_o   <= 1'b0;
    end else begin
      brake_lowside_o <= brake_req & ~cfg.brake_align_sel;
      brake_align_o   <= brake_req & cfg.brake_align_sel;
    end
  end

  property p_brake_none;
    @(posedge mclk_i) disable iff (!rst_b_i)
      cfg.brake_src == BRK_SRC_NONE |=> !brake_lowside_o && !brake_align_o;
  endproperty
  a_brake_none: assert property (p_brake_none) else $error("brake while override off");

  property p_brake_pin;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (cfg.brake_src == BRK_SRC_PIN || cfg.brake_src == BRK_SRC_PIN3)
        |=> (brake_lowside_o | brake_align_o) == $past(brake_pin_sync_i);
  endproperty
  a_brake_pin: assert property (p_brake_pin) else $error("brake not from pin");
endmodule

// ### hw/mpd_top.sv
// Pin function and system setup register bank for the sensorless motor drive
//
// Overview of operation
// - Tach fault code holds, forces high, forces low
// - Code three keeps tach toggling until back-EMF low
// - Brake source zero or three follows brake pin
// - Source one forces brake; bit five picks action
// - Source two ignores pin, never brakes
// - Hold angle bit: last angle or fixed angle
// - Speed source: analog, duty, bus, frequency
// - Monitor select: converter two, phases A, B, C
// - Dither bit: triangular sweep or random
// - Software writes key to lock/unlock storage
// - Key field always reads zero
// - Pull-up bit enables fault and tach pull-ups
// - Supply range code sets maximum bus voltage
`include "mpd_cfg.svh"

module mpd_top #(
  parameter int BEMF_W = 12,
  parameter int MON_W  = 10
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  // Register access from the serial target engine
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  output logic                        reg_ack_o,
  // Motor control side
  input  wire logic                   fault_i,
  input  wire logic                   tach_raw_i,
  input  wire logic [BEMF_W-1:0]      backemf_i,
  input  wire logic [BEMF_W-1:0]      backemf_tach_threshold_i,
  input  wire logic                   brake_pin_i,
  input  wire logic [MON_W-1:0]       monitor_converter_out_two_i,
  input  wire logic [MON_W-1:0]       phase_a_sense_out_i,
  input  wire logic [MON_W-1:0]       phase_b_sense_out_i,
  input  wire logic [MON_W-1:0]       phase_c_sense_out_i,
  output logic                        tach_output_o,
  output logic                        brake_lowside_o,
  output logic                        brake_align_o,
  output logic                        hold_angle_fixed_o,
  output mpd_pkg::mpd_speed_src_t     speed_ref_source_o,
  output logic      [MON_W-1:0]       monitor_out_o,
  output logic                        dither_random_o,
  output logic      [14:0]            lock_key_o,
  output logic                        lock_key_stb_o,
  output logic                        pullup_en_o,
  output mpd_pkg::mpd_supply_t        supply_rail_range_o,
  output logic      [6:0]             serial_target_addr_o,
  output logic      [1:0]             serial_slew_o
);
  import mpd_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_sys = reg_addr_i == `MPD_SYS_OFS;
  wire hit_pin = reg_addr_i == `MPD_PIN_OFS;
  wire wr_sys  = reg_wr_i & hit_sys;
  wire wr_pin  = reg_wr_i & hit_pin;

  logic [31:0] sys_reg;
  logic [31:0] pin_reg;
  logic [31:0] sys_next;
  logic [31:0] pin_next;
  logic [31:0] rdata_next;

  // Key and reserved bits are never stored, so they cannot leak back on a read
  assign sys_next = wr_sys ? (reg_wdata_i & `MPD_SYS_RD_MASK) : sys_reg;
  assign pin_next = wr_pin ? reg_wdata_i : pin_reg;

  // Unmapped addresses read as zero
  assign rdata_next = hit_sys ? (sys_reg & `MPD_SYS_RD_MASK) :
                      hit_pin ? pin_reg : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register storage and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_reg     <= `MPD_SYS_RST;
      pin_reg     <= `MPD_PIN_RST;
      reg_rdata_o <= 32'h0000_0000;
      reg_ack_o   <= 1'b0;
    end else begin
      sys_reg     <= sys_next;
      pin_reg     <= pin_next;
      reg_rdata_o <= reg_rd_i ? rdata_next : reg_rdata_o;
      reg_ack_o   <= reg_rd_i | reg_wr_i;
    end
  end

  // ----------------------------------------------------------------
  // Storage lock key hand-off
  // ----------------------------------------------------------------
  // The key is passed on as written; whether it matches is judged by the storage controller
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_key_o     <= 15'h0000;
      lock_key_stb_o <= 1'b0;
    end else begin
      lock_key_stb_o <= wr_sys;
      if (wr_sys) lock_key_o <= reg_wdata_i[`MPD_KEY_HI:`MPD_KEY_LO];
    end
  end

  // ----------------------------------------------------------------
  // Brake pin synchroniser
  // ----------------------------------------------------------------
  logic brake_meta_reg;
  logic brake_sync_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brake_meta_reg <= 1'b0;
      brake_sync_reg <= 1'b0;
    end else begin
      brake_meta_reg <= brake_pin_i;
      brake_sync_reg <= brake_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Helpers for tach and brake
  // ----------------------------------------------------------------
  mpd_cfg_if #(.BEMF_W(BEMF_W)) cfg_if ();

  assign cfg_if.tach_mode       = mpd_tach_mode_t'(pin_reg[`MPD_TACH_HI:`MPD_TACH_LO]);
  assign cfg_if.backemf         = backemf_i;
  assign cfg_if.bemf_thr        = backemf_tach_threshold_i;
  assign cfg_if.brake_src       = mpd_brake_src_t'(pin_reg[`MPD_BRK_SRC_HI:`MPD_BRK_SRC_LO]);
  assign cfg_if.brake_align_sel = pin_reg[`MPD_BRK_ACT_BIT];

  mpd_tach_ctl u_tach (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .cfg        (cfg_if),
    .fault_i    (fault_i),
    .tach_raw_i (tach_raw_i),
    .tach_o     (tach_output_o)
  );

  mpd_brake_ctl u_brake (
    .mclk_i           (mclk_i),
    .rst_b_i          (rst_b_i),
    .cfg              (cfg_if),
    .brake_pin_sync_i (brake_sync_reg),
    .brake_lowside_o  (brake_lowside_o),
    .brake_align_o    (brake_align_o)
  );

  // ----------------------------------------------------------------
  // Monitor routing and setup outputs
  // ----------------------------------------------------------------
  wire mpd_mon_sel_t mon_sel = mpd_mon_sel_t'(sys_reg[`MPD_MON_HI:`MPD_MON_LO]);
  logic [MON_W-1:0]  mon_pick;

  always_comb begin
    case (mon_sel)
      MON_PHASE_A: mon_pick = phase_a_sense_out_i;
      MON_PHASE_B: mon_pick = phase_b_sense_out_i;
      MON_PHASE_C: mon_pick = phase_c_sense_out_i;
      default:     mon_pick = monitor_converter_out_two_i;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      monitor_out_o        <= '0;
      hold_angle_fixed_o   <= 1'b0;
      speed_ref_source_o   <= SPD_ANALOG;
      dither_random_o      <= 1'b0;
      pullup_en_o          <= 1'b0;
      supply_rail_range_o  <= SUP_15V;
      serial_target_addr_o <= 7'h00;
      serial_slew_o        <= 2'b00;
    end else begin
      monitor_out_o        <= mon_pick;
      hold_angle_fixed_o   <= pin_reg[`MPD_HOLD_BIT];
      speed_ref_source_o   <= mpd_speed_src_t'(pin_reg[`MPD_SPD_HI:`MPD_SPD_LO]);
      dither_random_o      <= sys_reg[`MPD_DITH_BIT];
      pullup_en_o          <= sys_reg[`MPD_PULL_BIT];
      supply_rail_range_o  <= mpd_supply_t'(sys_reg[`MPD_SUP_HI:`MPD_SUP_LO]);
      serial_target_addr_o <= sys_reg[`MPD_TADDR_HI:`MPD_TADDR_LO];
      serial_slew_o        <= sys_reg[4:3];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_key_reads_zero;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_sys) |=> reg_rdata_o[`MPD_KEY_HI:`MPD_KEY_LO] == 15'h0000;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key field read back");

  property p_rsv_reads_zero;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_sys) |=> !reg_rdata_o[`MPD_RSV_BIT];
  endproperty
  a_rsv_reads_zero: assert property (p_rsv_reads_zero) else $error("reserved bit set");

  property p_key_strobe;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |=> lock_key_stb_o && lock_key_o == $past(reg_wdata_i[`MPD_KEY_HI:`MPD_KEY_LO]);
  endproperty
  a_key_strobe: assert property (p_key_strobe) else $error("key not passed on");

  property p_pullup_follows;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |-> ##2 pullup_en_o == $past(reg_wdata_i[`MPD_PULL_BIT], 2);
  endproperty
  a_pullup_follows: assert property (p_pullup_follows) else $error("pull-up not applied");

  property p_supply_follows;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |-> ##2 supply_rail_range_o == $past(reg_wdata_i[`MPD_SUP_HI:`MPD_SUP_LO], 2);
  endproperty
  a_supply_follows: assert property (p_supply_follows) else $error("supply range wrong");

  property p_taddr_follows;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |-> ##2 serial_target_addr_o == $past(reg_wdata_i[`MPD_TADDR_HI:`MPD_TADDR_LO], 2);
  endproperty
  a_taddr_follows: assert property (p_taddr_follows) else $error("target address wrong");

  property p_dither_follows;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |-> ##2 dither_random_o == $past(reg_wdata_i[`MPD_DITH_BIT], 2);
  endproperty
  a_dither_follows: assert property (p_dither_follows) else $error("dither mode wrong");

  property p_speed_src;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_pin |-> ##2 speed_ref_source_o == $past(reg_wdata_i[`MPD_SPD_HI:`MPD_SPD_LO], 2);
  endproperty
  a_speed_src: assert property (p_speed_src) else $error("speed source wrong");

  property p_hold_angle;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_pin |-> ##2 hold_angle_fixed_o == $past(reg_wdata_i[`MPD_HOLD_BIT], 2);
  endproperty
  a_hold_angle: assert property (p_hold_angle) else $error("hold angle source wrong");

  property p_force_brake;
    @(posedge mclk_i) disable iff (!rst_b_i)
      pin_reg[`MPD_BRK_SRC_HI:`MPD_BRK_SRC_LO] == 2'b01
        |=> (brake_align_o == $past(pin_reg[`MPD_BRK_ACT_BIT]))
            && (brake_lowside_o == !$past(pin_reg[`MPD_BRK_ACT_BIT]));
  endproperty
  a_force_brake: assert property (p_force_brake) else $error("forced brake wrong");

  property p_monitor_a;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mon_sel == MON_PHASE_A |=> monitor_out_o == $past(phase_a_sense_out_i);
  endproperty
  a_monitor_a: assert property (p_monitor_a) else $error("monitor not phase A");

  property p_monitor_conv;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mon_sel == MON_CONV_TWO |=> monitor_out_o == $past(monitor_converter_out_two_i);
  endproperty
  a_monitor_conv: assert property (p_monitor_conv) else $error("monitor not converter");

  property p_monitor_b;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mon_sel == MON_PHASE_B |=> monitor_out_o == $past(phase_b_sense_out_i);
  endproperty
  a_monitor_b: assert property (p_monitor_b) else $error("monitor not phase B");

  property p_monitor_c;
    @(posedge mclk_i) disable iff (!rst_b_i)
      mon_sel == MON_PHASE_C |=> monitor_out_o == $past(phase_c_sense_out_i);
  endproperty
  a_monitor_c: assert property (p_monitor_c) else $error("monitor not phase C");

  property p_key_not_stored;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |=> sys_reg[`MPD_KEY_HI:`MPD_KEY_LO] == 15'h0000;
  endproperty
  a_key_not_stored: assert property (p_key_not_stored) else $error("key kept in register");

  property p_rsv_ignores_write;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wr_sys |=> !sys_reg[`MPD_RSV_BIT];
  endproperty
  a_rsv_ignores_write: assert property (p_rsv_ignores_write) else $error("reserved bit stored");

  property p_key_no_strobe;
    @(posedge mclk_i) disable iff (!rst_b_i)
      !wr_sys |=> !lock_key_stb_o;
  endproperty
  a_key_no_strobe: assert property (p_key_no_strobe) else $error("key strobe without write");

  property p_sys_read_masked;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (reg_rd_i && hit_sys) |=> reg_rdata_o == ($past(sys_reg) & `MPD_SYS_RD_MASK);
  endproperty
  a_sys_read_masked: assert property (p_sys_read_masked) else $error("system read wrong");
endmodule

// ### tb/mpd_motor_model.sv
// Motor-side partner: tach pulses from a spinning rotor and monitor sources
module mpd_motor_model (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic run_i,
  output logic      tach_raw_o,
  output logic [9:0] mon_o [4]
);
  timeunit 1ns;
  timeprecision 1ps;

  // Distinct levels so a wrong selection never matches by chance
  assign mon_o[0] = 10'h1a5;
  assign mon_o[1] = 10'h05a;
  assign mon_o[2] = 10'h2c3;
  assign mon_o[3] = 10'h33c;

  // Tach toggles every cycle while running, a stopped rotor gives no edges
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tach_raw_o <= 1'b0;
    end else if (run_i) begin
      tach_raw_o <= !tach_raw_o;
    end
  end
endmodule

// ### tb/mpd_top_tb.sv
// Self-checking bench for the pin and device setup register bank
`include "mpd_cfg.svh"
module mpd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mpd_pkg::*;

  logic mclk = 0, rst_b = 0, wr = 0, rd = 0, fault = 0, brk = 0, run = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [11:0] bemf = 12'h100, thr = 12'h080;
  logic [9:0] mon [4];
  logic [9:0] mout;
  logic ack, raw, tach, blow, balign, hold, dith, kstb, pull;
  logic [14:0] key;
  logic [6:0] taddr;
  logic [1:0] slew;
  mpd_speed_src_t spd;
  mpd_supply_t sup;
  logic [32:0] expq [$];
  logic [32:0] note;
  logic [15:0] lf = 16'h5c44;
  int fail_count = 0;
  int n_checks = 0;

  always #12.5 mclk = ~mclk;

  mpd_motor_model i_motor (.mclk_i(mclk), .rst_b_i(rst_b), .run_i(run), .tach_raw_o(raw),
    .mon_o(mon));

  mpd_top i_dut (.mclk_i(mclk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .fault_i(fault), .tach_raw_i(raw), .backemf_i(bemf), .backemf_tach_threshold_i(thr),
    .brake_pin_i(brk), .monitor_converter_out_two_i(mon[0]), .phase_a_sense_out_i(mon[1]),
    .phase_b_sense_out_i(mon[2]), .phase_c_sense_out_i(mon[3]), .tach_output_o(tach),
    .brake_lowside_o(blow), .brake_align_o(balign), .hold_angle_fixed_o(hold),
    .speed_ref_source_o(spd), .monitor_out_o(mout), .dither_random_o(dith),
    .lock_key_o(key), .lock_key_stb_o(kstb), .pullup_en_o(pull),
    .supply_rail_range_o(sup), .serial_target_addr_o(taddr), .serial_slew_o(slew));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One strobe per access; bit 32 of the note marks a read to compare
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    expq.push_back(e);
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Response watcher
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (ack === 1'b1) begin
      if (expq.size() == 0) begin
        chk(32'h1, 32'h0, "ack without request");
      end else if (expq[0][32]) begin
        note = expq.pop_front();
        chk(rdata, note[31:0], "read data");
      end else begin
        void'(expq.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic t0, t1, eb;
    repeat (10) @(posedge mclk);
    chk({pull, sup, taddr, dith, key}, 32'h0, "reset outputs");
    // Release between edges so flops and checks agree on the first live edge
    @(negedge mclk);
    rst_b <= 1'b1;
    run <= 1'b1;
    acc(1'b0, `MPD_SYS_OFS, 32'h0, {1'b1, `MPD_SYS_RST});
    acc(1'b0, `MPD_PIN_OFS, 32'h0, {1'b1, `MPD_PIN_RST});
    acc(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      d[31:16] = lf;
      lf = lfsr(lf);
      d[15:0] = lf;
      d[29:28] = i[1:0];
      d[1:0] = ~i[1:0];
      acc(1'b1, `MPD_SYS_OFS, d, 33'h0);
      #1;
      chk({kstb, key}, {1'b1, d[19:5]}, "key strobe");
      repeat (2) @(posedge mclk);
      #1;
      chk(pull, d[2], "pull-up");
      chk(sup, d[1:0], "supply range");
      chk(taddr, d[26:20], "target address");
      chk(dith, d[27], "dither");
      chk(slew, d[4:3], "slew pass-through");
      chk(mout, mon[d[29:28]], "monitor route");
      acc(1'b0, `MPD_SYS_OFS, 32'h0, {1'b1, d & `MPD_SYS_RD_MASK});
    end
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      d = {lf, lf} & 32'hffff_fe00;
      d[1:0] = i[1:0];
      d[4] = i[2];
      acc(1'b1, `MPD_PIN_OFS, d, 33'h0);
      repeat (2) @(posedge mclk);
      #1;
      chk({hold, spd}, {i[2], i[1:0]}, "speed and hold");
      acc(1'b0, `MPD_PIN_OFS, 32'h0, {1'b1, d});
    end
    for (int k = 0; k < 16; k++) begin
      d = 32'h0;
      d[3:2] = k[1:0];
      d[5] = k[2];
      @(posedge mclk);
      brk <= k[3];
      acc(1'b1, `MPD_PIN_OFS, d, 33'h0);
      repeat (5) @(posedge mclk);
      #1;
      eb = (k[1:0] == 2'd1) || (k[1:0] != 2'd2 && k[3]);
      chk({blow, balign}, {eb & !k[2], eb & k[2]}, "brake");
    end
    for (int m = 0; m < 4; m++) begin
      d = 32'h0;
      d[8:7] = m[1:0];
      acc(1'b1, `MPD_PIN_OFS, d, 33'h0);
      repeat (2) @(posedge mclk);
      fault <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      t0 = tach;
      @(posedge mclk);
      #1;
      t1 = tach;
      if (m == 1 || m == 2) begin
        chk({t0, t1}, {2{m == 1}}, "tach forced");
      end else begin
        chk(t1, (m == 3) ? !t0 : t0, "tach in fault");
      end
      if (m == 3) begin
        @(posedge mclk);
        bemf <= 12'h040;
        repeat (4) @(posedge mclk);
        #1;
        t0 = tach;
        @(posedge mclk);
        #1;
        chk(tach, t0, "tach after back-EMF low");
        bemf <= 12'h100;
      end
      @(posedge mclk);
      fault <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    chk(expq.size(), 32'h0, "missing acks");
    finish_test();
  end
endmodule
